// >>> bench/tb.sv
// self-checking bench of the 16-bit timer mode sequencer
`timescale 1ns/1ps
`include "tms_map.vh"
module tb;
  logic pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  wire [31:0] prdata;
  wire pready, pslverr, pin, oe;
  int n_fail, n_compared, g, lv;
  int fac[5] = '{1, 8, 64, 256, 1024};
  int tp[4] = '{255, 511, 1023, 255};
  logic [3:0] md[4] = '{4'h5, 4'h6, 4'h7, 4'he};
  logic [15:0] rn;
  logic [63:0] eq[$];
  tms_timer16 uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .compare_a_pin_out(pin), .compare_a_pin_oe(oe));
  // ====
  // helpers
  task automatic chk(input logic [31:0] s, input logic [31:0] w);
    n_compared++;
    if (s !== w) begin
      n_fail++;
      $display("[FAIL] %0t seen=%h want=%h", $time, s, w);
    end
  endtask
  task automatic print_verdict;
    if (n_fail == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [31:0] ctl(input logic [3:0] m,
    input logic [1:0] c, input int s);
    return {19'h0, 1'b1, 1'b0, s[2:0], 2'h0, c, m};
  endfunction
  task automatic apb(input logic [11:0] a, input logic w,
    input logic [31:0] d, m);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    if (!w) eq.push_back({m, d & m});
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d, 32'h0);
  endtask
  // cycles until the pin changes level; lv keeps the level timed
  task automatic run_len;
    logic v;
    g = 0;
    v = pin;
    while (pin === v && g < 9000) begin
      @(posedge pclk);
      g++;
    end
    lv = v;
  endtask
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial begin
    repeat (90000) @(posedge pclk);
    n_fail++;
    print_verdict();
  end
  always @(posedge pclk) begin
    logic [63:0] e;
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      e = eq.pop_front();
      chk(prdata & e[63:32], e[31:0]);
    end
  end
  // ====
  // scenarios
  initial begin
    n_fail = 0;
    n_compared = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    rn = 16'h001d;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(`TMS_OFF_CTRL, 1'b0, 32'h0, 32'hffffffff);
    apb(12'h014, 1'b0, 32'h0, 32'hffffffff);
    // timer stopped: written values must stay put
    for (int i = 0; i < 3; i++) begin
      rn = nxt(rn);
      wr(`TMS_OFF_COUNT, {rn, rn});
      apb(`TMS_OFF_COUNT, 1'b0, {16'h0, rn}, 32'hffffffff);
      wr(`TMS_OFF_CAPT, {rn, rn});
      apb(`TMS_OFF_CAPT, 1'b0, {16'h0, rn}, 32'hffffffff);
    end
    wr(`TMS_OFF_COUNT, 32'hfff0);
    wr(`TMS_OFF_FLAGS, 32'h7);
    apb(`TMS_OFF_FLAGS, 1'b0, 32'h0, 32'h1);
    wr(`TMS_OFF_CTRL, {28'h0, `TMS_WGM_NORMAL} | 32'h100);
    repeat (40) @(posedge pclk);
    wr(`TMS_OFF_CTRL, 32'h0);
    apb(`TMS_OFF_FLAGS, 1'b0, 32'h1, 32'h1);
    apb(`TMS_OFF_COUNT, 1'b0, 32'h0, 32'hffc0);
    wr(`TMS_OFF_CMPA, 32'h3);
    wr(`TMS_OFF_CAPT, 32'h7);
    for (int i = 0; i < 6; i++) begin
      wr(`TMS_OFF_CTRL, ctl(i < 5 ? `TMS_WGM_CTC_A : `TMS_WGM_CTC_I,
        `TMS_COM_TOGGLE, i < 5 ? i + 1 : 1));
      // a count left above top would run to max before the first match
      wr(`TMS_OFF_COUNT, 32'h0);
      wr(`TMS_OFF_FLAGS, 32'h7);
      run_len();
      run_len();
      chk(g, i < 5 ? 4 * fac[i] : 8);
      apb(`TMS_OFF_FLAGS, 1'b0, i < 5 ? 2 : 4, i < 5 ? 2 : 4);
    end
    wr(`TMS_OFF_CAPT, 32'hff);
    wr(`TMS_OFF_CMPA, 32'h40);
    for (int i = 0; i < 8; i++) begin
      wr(`TMS_OFF_CTRL, ctl(md[i / 2], 2'(2 + i % 2), 1));
      wr(`TMS_OFF_COUNT, 32'h0);
      repeat (3) run_len();
      repeat (2) begin
        run_len();
        chk(g, (lv ^ (i % 2)) ? tp[i / 2] - 64 : 65);
      end
    end
    print_verdict();
  end
endmodule // tb
bind tms_timer16 tms_timer16_props u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .compare_a_pin_out(compare_a_pin_out),
  .compare_a_pin_oe(compare_a_pin_oe));

// >>> bench/tms_timer16_props.sv
// concurrent checks on the timer's apb and pin ports
`timescale 1ns/1ps
module tms_timer16_props (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire compare_a_pin_out,
  input wire compare_a_pin_oe
);
  // ====
  // apb handshake and pin gating
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire ctl_wr = psel && penable && pready && pwrite && paddr == 12'h000;
  property p_rdy_setup; psel && !penable |=> pready; endproperty
  a_rdy_setup: assert property (p_rdy_setup)
    else $error("no pready after setup");
  property p_rdy_once; pready |=> !pready; endproperty
  a_rdy_once: assert property (p_rdy_once)
    else $error("pready held two cycles");
  property p_rdy_acc; pready |-> psel && penable; endproperty
  a_rdy_acc: assert property (p_rdy_acc)
    else $error("pready outside access");
  property p_err_map; pready |-> pslverr == (paddr > 12'h010); endproperty
  a_err_map: assert property (p_err_map)
    else $error("pslverr wrong for address");
  property p_err_rd; pready && pslverr && !pwrite |-> prdata == 32'h0;
  endproperty
  a_err_rd: assert property (p_err_rd)
    else $error("refused read returned data");
  property p_oe_dir;
    ctl_wr |-> ##2 compare_a_pin_oe == $past(pwdata[12], 2);
  endproperty
  a_oe_dir: assert property (p_oe_dir)
    else $error("pin enable not following direction");
  property p_pin_oe; !compare_a_pin_oe |-> !compare_a_pin_out; endproperty
  a_pin_oe: assert property (p_pin_oe)
    else $error("pin driven while input");
  property p_com0; ctl_wr && pwdata[5:4] == 2'h0 |-> ##2 !compare_a_pin_out;
  endproperty
  a_com0: assert property (p_com0)
    else $error("pin active with output mode off");
endmodule // tms_timer16_props

// >>> hw/tms_timer16.v
// apb-controlled 16-bit timer with normal, clear-on-match and fast pwm modes
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "tms_map.vh"
module tms_timer16 (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg compare_a_pin_out,
  output reg compare_a_pin_oe
);

  // ==========================================================
  // state
  reg [12:0] ctrl_q;
  reg [15:0] count_value_q;
  reg [15:0] compare_a_value_q;
  reg [15:0] compare_a_buf_q;
  reg [15:0] capture_top_value_q;
  reg overflow_flag_q;
  reg compare_a_flag_q;
  reg capture_flag_q;
  reg compare_a_output_q;
  reg [9:0] presc_q;
  reg tick_q;
  reg block_q;

  wire [3:0] waveform_mode_select;
  wire [1:0] compare_output_mode;
  wire [2:0] clock_select;
  wire pin_direction_bit;
  assign waveform_mode_select = ctrl_q[`TMS_CTRL_WGM_LSB +: 4];
  assign compare_output_mode = ctrl_q[`TMS_CTRL_COM_LSB +: 2];
  assign clock_select = ctrl_q[`TMS_CTRL_CS_LSB +: 3];
  assign pin_direction_bit = ctrl_q[`TMS_CTRL_DDR_BIT];

  // ==========================================================
  // apb decode
  wire acc;
  wire wr;
  wire rd;
  wire mapped;
  // an access completes on the edge that sees psel, penable and pready
  assign acc = psel & penable & pready;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  // strobes and error answer share one decoder, so a word that answers
  // without error is always a word that can be written
  function reg_hit;
    input [11:0] a;
    input [11:0] off;
    begin
      reg_hit = (a == off);
    end
  endfunction

  assign mapped = reg_hit(paddr, `TMS_OFF_CTRL) |
                  reg_hit(paddr, `TMS_OFF_COUNT) |
                  reg_hit(paddr, `TMS_OFF_CMPA) |
                  reg_hit(paddr, `TMS_OFF_CAPT) |
                  reg_hit(paddr, `TMS_OFF_FLAGS);
  wire wr_ctrl;
  wire wr_count;
  wire wr_cmpa;
  wire wr_capt;
  wire wr_flags;
  assign wr_ctrl = wr & reg_hit(paddr, `TMS_OFF_CTRL);
  assign wr_count = wr & reg_hit(paddr, `TMS_OFF_COUNT);
  assign wr_cmpa = wr & reg_hit(paddr, `TMS_OFF_CMPA);
  assign wr_capt = wr & reg_hit(paddr, `TMS_OFF_CAPT);
  assign wr_flags = wr & reg_hit(paddr, `TMS_OFF_FLAGS);

  // ==========================================================
  // mode decode
  function is_fast;
    input [3:0] m;
    begin
      is_fast = (m == `TMS_WGM_FAST8) | (m == `TMS_WGM_FAST9) |
                (m == `TMS_WGM_FAST10) | (m == `TMS_WGM_FAST_I) |
                (m == `TMS_WGM_FAST_A);
    end
  endfunction

  wire mode_ctc;
  wire mode_fast;
  wire top_is_capt;
  wire top_is_cmpa;
  // codes that none of the decodes below claim count like normal mode:
  // up to max, then wrap with an overflow
  assign mode_ctc = (waveform_mode_select == `TMS_WGM_CTC_A) |
                    (waveform_mode_select == `TMS_WGM_CTC_I);
  assign mode_fast = is_fast(waveform_mode_select);
  assign top_is_capt = (waveform_mode_select == `TMS_WGM_CTC_I) |
                       (waveform_mode_select == `TMS_WGM_FAST_I);
  assign top_is_cmpa = (waveform_mode_select == `TMS_WGM_CTC_A) |
                       (waveform_mode_select == `TMS_WGM_FAST_A);

  reg [15:0] top;
  always @* begin
    case (waveform_mode_select)
      `TMS_WGM_FAST8: top = `TMS_TOP8;
      `TMS_WGM_FAST9: top = `TMS_TOP9;
      `TMS_WGM_FAST10: top = `TMS_TOP10;
      `TMS_WGM_CTC_I, `TMS_WGM_FAST_I: top = capture_top_value_q;
      `TMS_WGM_CTC_A, `TMS_WGM_FAST_A: top = compare_a_value_q;
      default: top = `TMS_MAX;
    endcase
  end

  // ==========================================================
  // prescaler: one-cycle tick enable
  reg [9:0] div_lim;
  always @* begin
    case (clock_select)
      3'h1: div_lim = 10'h000;
      3'h2: div_lim = `TMS_DIV8;
      3'h3: div_lim = `TMS_DIV64;
      3'h4: div_lim = `TMS_DIV256;
      3'h5: div_lim = `TMS_DIV1024;
      default: div_lim = 10'h000;
    endcase
  end
  // a stopped divider is held at zero, so a restart begins a full period;
  // the tick register adds one cycle of latency after a start
  wire run;
  assign run = (clock_select >= 3'h1) & (clock_select <= 3'h5);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_q <= 10'h000;
      tick_q <= 1'b0;
    end else if (!run) begin
      presc_q <= 10'h000;
      tick_q <= 1'b0;
    end else if (presc_q >= div_lim) begin
      presc_q <= 10'h000;
      tick_q <= 1'b1;
    end else begin
      presc_q <= presc_q + 10'h001;
      tick_q <= 1'b0;
    end
  end

  // ==========================================================
  // counter, matches, flags
  // matches are judged on the value held before the tick, so a match and
  // the step it causes land on the same edge
  wire at_top;
  wire at_max;
  wire cmp_match;
  wire top_match;
  assign at_top = (count_value_q == top);
  assign at_max = (count_value_q == `TMS_MAX);
  // a count write suppresses the match of the following tick
  assign cmp_match = tick_q & ~block_q & (count_value_q == compare_a_value_q);
  assign top_match = tick_q & ~block_q & at_top & (mode_ctc | mode_fast);

  reg [15:0] count_d;
  always @* begin
    count_d = count_value_q;
    if (tick_q) begin
      if (top_match)
        count_d = 16'h0000;
      else
        count_d = count_value_q + 16'h0001;
    end
  end

  // outside fast pwm every pass from max to zero counts; in fast pwm the flag
  // marks each top clear at any top, and a wrap at max is not counted
  wire ovf_evt;
  assign ovf_evt = tick_q & (mode_fast ? top_match : at_max);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_value_q <= 16'h0000;
      block_q <= 1'b0;
    end else begin
      if (wr_count) begin
        count_value_q <= pwdata[15:0];
        block_q <= 1'b1;
      end else begin
        count_value_q <= count_d;
        if (tick_q)
          block_q <= 1'b0;
      end
    end
  end

  // software clears by writing one; a set in the same cycle wins
  reg overflow_flag_d;
  reg compare_a_flag_d;
  reg capture_flag_d;
  always @* begin
    overflow_flag_d = overflow_flag_q;
    compare_a_flag_d = compare_a_flag_q;
    capture_flag_d = capture_flag_q;
    if (wr_flags & pwdata[`TMS_FLG_OVF_BIT])
      overflow_flag_d = 1'b0;
    if (wr_flags & pwdata[`TMS_FLG_CMPA_BIT])
      compare_a_flag_d = 1'b0;
    if (wr_flags & pwdata[`TMS_FLG_CAPT_BIT])
      capture_flag_d = 1'b0;
    // hardware only ever sets; these come last so a set beats a clear
    if (ovf_evt)
      overflow_flag_d = 1'b1;
    if (cmp_match | (top_match & top_is_cmpa))
      compare_a_flag_d = 1'b1;
    if (top_match & top_is_capt)
      capture_flag_d = 1'b1;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag_q <= 1'b0;
      compare_a_flag_q <= 1'b0;
      capture_flag_q <= 1'b0;
    end else begin
      overflow_flag_q <= overflow_flag_d;
      compare_a_flag_q <= compare_a_flag_d;
      capture_flag_q <= capture_flag_d;
    end
  end

  // ==========================================================
  // compare registers; compare a buffered in fast pwm only, capture top never buffered
  // a top written below the count is missed until the counter wraps at
  // max; only the pwm path buffers compare a to avoid that
  wire cmpa_load;
  assign cmpa_load = mode_fast & top_match;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_a_value_q <= 16'h0000;
      compare_a_buf_q <= 16'h0000;
      capture_top_value_q <= 16'h0000;
    end else begin
      if (wr_capt)
        capture_top_value_q <= pwdata[15:0];
      if (wr_cmpa)
        compare_a_buf_q <= pwdata[15:0];
      if (!mode_fast) begin
        if (wr_cmpa)
          compare_a_value_q <= pwdata[15:0];
      end else if (cmpa_load) begin
        compare_a_value_q <= compare_a_buf_q;
      end
    end
  end

  // ==========================================================
  // waveform output
  // the output register keeps its level across mode changes, so software
  // can settle it before the pin is turned to output
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_a_output_q <= 1'b0;
    end else if (mode_fast) begin
      case (compare_output_mode)
        `TMS_COM_TOGGLE: begin
          if (cmp_match & top_is_cmpa)
            compare_a_output_q <= ~compare_a_output_q;
        end
        `TMS_COM_NONINV: begin
          if (top_match)
            compare_a_output_q <= 1'b0;
          else if (cmp_match)
            compare_a_output_q <= 1'b1;
        end
        `TMS_COM_INV: begin
          if (top_match)
            compare_a_output_q <= 1'b1;
          else if (cmp_match)
            compare_a_output_q <= 1'b0;
        end
        default: ;
      endcase
    end else if (cmp_match) begin
      case (compare_output_mode)
        `TMS_COM_TOGGLE: compare_a_output_q <= ~compare_a_output_q;
        `TMS_COM_NONINV: compare_a_output_q <= 1'b0;
        `TMS_COM_INV: compare_a_output_q <= 1'b1;
        default: ;
      endcase
    end
  end

  // pin follows the port latch (zero) while output mode is off
  // direction and level are both registered so they switch on one edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_a_pin_out <= 1'b0;
      compare_a_pin_oe <= 1'b0;
    end else begin
      compare_a_pin_oe <= pin_direction_bit;
      compare_a_pin_out <= pin_direction_bit &
                           (compare_output_mode != `TMS_COM_OFF) &
                           compare_a_output_q;
    end
  end

  // ==========================================================
  // read word: taken in the setup cycle so it stands for the whole access
  // cycle; compare a reads back the buffer, i.e. what software wrote
  reg [31:0] rd_word;
  always @* begin
    case (paddr)
      `TMS_OFF_CTRL: rd_word = {19'h00000, ctrl_q};
      `TMS_OFF_COUNT: rd_word = {16'h0000, count_value_q};
      `TMS_OFF_CMPA: rd_word = {16'h0000, compare_a_buf_q};
      `TMS_OFF_CAPT: rd_word = {16'h0000, capture_top_value_q};
      `TMS_OFF_FLAGS: rd_word = {29'h00000000, capture_flag_q,
                                 compare_a_flag_q, overflow_flag_q};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // ==========================================================
  // control register and apb answer (zero wait states)
  // unused control bits read back as written; they steer nothing
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `TMS_RST_CTRL;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      if (wr_ctrl)
        ctrl_q <= pwdata[12:0];
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (psel & ~penable & ~pwrite)
        prdata <= rd_word;
      else if (rd)
        prdata <= 32'h0000_0000;
    end
  end

endmodule // tms_timer16

// >>> inc/tms_map.vh
// constants of the 16-bit timer mode sequencer
`ifndef TMS_MAP_VH
`define TMS_MAP_VH
`define TMS_OFF_CTRL 12'h000
`define TMS_OFF_COUNT 12'h004
`define TMS_OFF_CMPA 12'h008
`define TMS_OFF_CAPT 12'h00c
`define TMS_OFF_FLAGS 12'h010
`define TMS_CTRL_WGM_LSB 0
`define TMS_CTRL_COM_LSB 4
`define TMS_CTRL_CS_LSB 8
`define TMS_CTRL_DDR_BIT 12
`define TMS_FLG_OVF_BIT 0
`define TMS_FLG_CMPA_BIT 1
`define TMS_FLG_CAPT_BIT 2
`define TMS_WGM_NORMAL 4'h0
`define TMS_WGM_CTC_A 4'h4
`define TMS_WGM_FAST8 4'h5
`define TMS_WGM_FAST9 4'h6
`define TMS_WGM_FAST10 4'h7
`define TMS_WGM_CTC_I 4'hc
`define TMS_WGM_FAST_I 4'he
`define TMS_WGM_FAST_A 4'hf
`define TMS_TOP8 16'h00ff
`define TMS_TOP9 16'h01ff
`define TMS_TOP10 16'h03ff
`define TMS_MAX 16'hffff
`define TMS_COM_OFF 2'h0
`define TMS_COM_TOGGLE 2'h1
`define TMS_COM_NONINV 2'h2
`define TMS_COM_INV 2'h3
`define TMS_DIV8 10'h007
`define TMS_DIV64 10'h03f
`define TMS_DIV256 10'h0ff
`define TMS_DIV1024 10'h3ff
`define TMS_RST_CTRL 13'h0000
`endif
